// File: isd_pkg.sv
// Package for the input synchronisation parameter object and profile.
// Assumes a single clock domain and an index/subindex parameter port.
package isd_pkg;

    // Object indices
    localparam logic [15:0] ISD_IDX_SYNC_IN = 16'h1c33;
    localparam logic [15:0] ISD_IDX_PROFILE = 16'hf000;

    // Subindices of the synchronisation object
    localparam logic [7:0] ISD_SUB_COUNT = 8'h00;
    localparam logic [7:0] ISD_SUB_MODE = 8'h01;
    localparam logic [7:0] ISD_SUB_CYCLE = 8'h02;
    localparam logic [7:0] ISD_SUB_SHIFT = 8'h03;
    localparam logic [7:0] ISD_SUB_SUPPORT = 8'h04;
    localparam logic [7:0] ISD_SUB_MIN_CYCLE = 8'h05;
    localparam logic [7:0] ISD_SUB_COPY = 8'h06;
    localparam logic [7:0] ISD_SUB_COMMAND = 8'h08;
    localparam logic [7:0] ISD_SUB_DELAY = 8'h09;
    localparam logic [7:0] ISD_SUB_MISSED = 8'h0b;
    localparam logic [7:0] ISD_SUB_OVERRUN = 8'h0c;
    localparam logic [7:0] ISD_SUB_SHORT = 8'h0d;
    localparam logic [7:0] ISD_SUB_SYNC_ERR = 8'h20;

    // Subindices of the modular profile object
    localparam logic [7:0] ISD_SUB_PROF_COUNT = 8'h00;
    localparam logic [7:0] ISD_SUB_PROF_SPACING = 8'h01;
    localparam logic [7:0] ISD_SUB_PROF_CHANNELS = 8'h02;

    // Constant and reset values
    localparam logic [7:0] ISD_ENTRY_COUNT = 8'h20;
    localparam logic [31:0] ISD_CYCLE_RST = 32'h017d_7840;
    localparam logic [31:0] ISD_TIME_RST = 32'h0000_0000;
    localparam logic [15:0] ISD_SUPPORT_MAP = 16'hc007;
    localparam logic [31:0] ISD_MIN_CYCLE = 32'h0002_22e0;
    localparam logic [15:0] ISD_COUNT_RST = 16'h0000;
    localparam logic [7:0] ISD_PROF_COUNT = 8'h02;
    localparam logic [15:0] ISD_PROF_SPACING = 16'h0010;
    localparam logic [15:0] ISD_PROF_CHANNELS = 16'h0001;

    // Measurement command codes
    localparam logic [15:0] ISD_CMD_STOP = 16'h0000;
    localparam logic [15:0] ISD_CMD_START = 16'h0001;

    typedef enum logic [15:0] {
        ISD_MODE_FREE = 16'h0000,
        ISD_MODE_SM3 = 16'h0001,
        ISD_MODE_SYNC0 = 16'h0002,
        ISD_MODE_SYNC1 = 16'h0003,
        ISD_MODE_SM2 = 16'h0022
    } isd_mode_t;

    localparam isd_mode_t ISD_MODE_RST = ISD_MODE_SM2;

    typedef struct packed {
        logic write;
        logic [15:0] index;
        logic [7:0] subindex;
        logic [31:0] wdata;
    } isd_req_t;

    typedef struct packed {
        logic abort;
        logic [31:0] rdata;
    } isd_rsp_t;

    typedef struct packed {
        logic sm_missed;
        logic cycle_over;
        logic shift_short;
        logic cycle_done;
        logic sync_fault;
    } isd_evt_t;

    typedef struct packed {
        logic valid;
        logic [31:0] shift_ns;
        logic [31:0] copy_ns;
        logic [31:0] delay_ns;
    } isd_meas_t;

endpackage

// File: isd_sync_params.sv
// Input synchronisation parameter object with timing monitor counters.
// Assumes the mailbox side issues one request at a time and that event
// and measurement inputs are synchronous one-cycle strobes.
//
// Contract
// - Entry count reads constant 32
// - Writable mode code, default 34
// - Writable cycle time, default 25000000 ns
// - Writable shift time, default zero
// - Supported modes bitmap reads 0xC007
// - Minimum cycle time reads 140000 ns
// - Read-only calc and copy time
// - Command 1 starts, 0 stops measurement
// - Keep maxima; clear on new measurement
// - Read-only SYNC1 to sample delay
// - Count missed events, operational DC mode
// - Count cycle overruns in operational state
// - Count too-short SYNC0/SYNC1 spacing, DC mode
// - Sync error flag from last DC cycle
// - Profile: two entries, spacing 16, one channel
`timescale 1ns/100ps

module isd_sync_params (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Parameter access from the mailbox side
    input wire logic req_valid_i,
    input wire isd_pkg::isd_req_t req_i,
    output logic rsp_valid_o,
    output isd_pkg::isd_rsp_t rsp_o,
    // Device state and timing events
    input wire logic op_state_i,
    input wire isd_pkg::isd_evt_t evt_i,
    input wire isd_pkg::isd_meas_t meas_i,
    // Configuration seen by the sampling logic
    output isd_pkg::isd_mode_t sync_mode_o,
    output logic [31:0] cycle_ns_o,
    output logic [31:0] shift_ns_o,
    output logic measure_on_o,
    output logic dc_mode_o
);
    import isd_pkg::*;

    // Saturating increment for the monitor counters
    function automatic logic [15:0] sat_inc(input logic [15:0] v,
                                            input logic hit);
        if (hit && (v != 16'hffff)) begin
            return v + 16'h0001;
        end
        return v;
    endfunction

    function automatic logic [31:0] max32(input logic [31:0] a,
                                          input logic [31:0] b);
        return (b > a) ? b : a;
    endfunction

    function automatic logic legal_mode(input logic [15:0] m);
        return (m == ISD_MODE_FREE) || (m == ISD_MODE_SM3) ||
               (m == ISD_MODE_SYNC0) || (m == ISD_MODE_SYNC1) ||
               (m == ISD_MODE_SM2);
    endfunction

    // Configuration and measurement state
    isd_mode_t mode_q, mode_d;
    logic [31:0] cycle_q, cycle_d;
    logic [31:0] shift_q, shift_d;
    logic [31:0] copy_q, copy_d;
    logic [31:0] delay_q, delay_d;
    logic [15:0] cmd_q, cmd_d;

    // Monitor state
    logic [15:0] missed_q, missed_d;
    logic [15:0] overrun_q, overrun_d;
    logic [15:0] short_q, short_d;
    logic sync_err_q, sync_err_d;

    // Response state
    logic rsp_valid_q, rsp_valid_d;
    isd_rsp_t rsp_q, rsp_d;

    logic dc_mode;
    logic measuring;
    logic wr;
    logic [23:0] key;

    assign dc_mode = (mode_q == ISD_MODE_SYNC0) ||
                     (mode_q == ISD_MODE_SYNC1);
    assign measuring = (cmd_q == ISD_CMD_START);
    assign wr = req_valid_i && req_i.write;
    assign key = {req_i.index, req_i.subindex};

    // Configuration and measured times
    always_comb begin
        mode_d = mode_q;
        cycle_d = cycle_q;
        shift_d = shift_q;
        copy_d = copy_q;
        delay_d = delay_q;
        cmd_d = cmd_q;
        // Track maxima while a measurement runs
        if (measuring && meas_i.valid) begin
            shift_d = max32(shift_q, meas_i.shift_ns);
            copy_d = max32(copy_q, meas_i.copy_ns);
            delay_d = max32(delay_q, meas_i.delay_ns);
        end
        // Master writes come last, so they win over a same-cycle sample
        if (wr) begin
            unique case (key)
                {ISD_IDX_SYNC_IN, ISD_SUB_MODE}: begin
                    if (legal_mode(req_i.wdata[15:0])) begin
                        mode_d = isd_mode_t'(req_i.wdata[15:0]);
                    end
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_CYCLE}: begin
                    cycle_d = req_i.wdata;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_SHIFT}: begin
                    shift_d = req_i.wdata;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_COMMAND}: begin
                    if (req_i.wdata[15:0] == ISD_CMD_START) begin
                        cmd_d = ISD_CMD_START;
                        // A fresh run starts from cleared maxima
                        shift_d = ISD_TIME_RST;
                        copy_d = ISD_TIME_RST;
                        delay_d = ISD_TIME_RST;
                    end else if (req_i.wdata[15:0] == ISD_CMD_STOP) begin
                        cmd_d = ISD_CMD_STOP;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mode_q <= ISD_MODE_RST;
            cycle_q <= ISD_CYCLE_RST;
            shift_q <= ISD_TIME_RST;
            copy_q <= ISD_TIME_RST;
            delay_q <= ISD_TIME_RST;
            cmd_q <= ISD_CMD_STOP;
        end else begin
            mode_q <= mode_d;
            cycle_q <= cycle_d;
            shift_q <= shift_d;
            copy_q <= copy_d;
            delay_q <= delay_d;
            cmd_q <= cmd_d;
        end
    end

    // Event strobes qualified by device state and mode
    logic missed_hit;
    logic overrun_hit;
    logic short_hit;
    logic fault_take;

    // Missed events only count while operational in DC mode
    assign missed_hit = evt_i.sm_missed && op_state_i && dc_mode;
    // Overruns count in the operational state, in any mode
    assign overrun_hit = evt_i.cycle_over && op_state_i;
    // Short SYNC0/SYNC1 spacing only matters in DC mode
    assign short_hit = evt_i.shift_short && dc_mode;
    // The flag follows the fault strobe once per finished cycle
    assign fault_take = dc_mode && evt_i.cycle_done;

    // Timing fault counters and sync error flag
    always_comb begin
        // Counters stop at all ones so a long fault burst never wraps
        missed_d = sat_inc(missed_q, missed_hit);
        overrun_d = sat_inc(overrun_q, overrun_hit);
        short_d = sat_inc(short_q, short_hit);
        sync_err_d = sync_err_q;
        if (!dc_mode) begin
            sync_err_d = 1'b0;
        end else if (fault_take) begin
            sync_err_d = evt_i.sync_fault;
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            missed_q <= ISD_COUNT_RST;
            overrun_q <= ISD_COUNT_RST;
            short_q <= ISD_COUNT_RST;
            sync_err_q <= 1'b0;
        end else begin
            missed_q <= missed_d;
            overrun_q <= overrun_d;
            short_q <= short_d;
            sync_err_q <= sync_err_d;
        end
    end

    // Access response: read data, or abort for bad access
    always_comb begin
        rsp_valid_d = req_valid_i;
        rsp_d.abort = 1'b0;
        rsp_d.rdata = 32'h0000_0000;
        if (req_valid_i) begin
            unique case (key)
                {ISD_IDX_SYNC_IN, ISD_SUB_COUNT}: begin
                    rsp_d.rdata = {24'h00_0000, ISD_ENTRY_COUNT};
                    rsp_d.abort = wr;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_MODE}: begin
                    rsp_d.rdata = {16'h0000, mode_q};
                    rsp_d.abort = wr && !legal_mode(req_i.wdata[15:0]);
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_CYCLE}: begin
                    rsp_d.rdata = cycle_q;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_SHIFT}: begin
                    rsp_d.rdata = shift_q;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_SUPPORT}: begin
                    rsp_d.rdata = {16'h0000, ISD_SUPPORT_MAP};
                    rsp_d.abort = wr;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_MIN_CYCLE}: begin
                    rsp_d.rdata = ISD_MIN_CYCLE;
                    rsp_d.abort = wr;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_COPY}: begin
                    rsp_d.rdata = copy_q;
                    rsp_d.abort = wr;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_COMMAND}: begin
                    rsp_d.rdata = {16'h0000, cmd_q};
                    rsp_d.abort = wr &&
                        (req_i.wdata[15:0] != ISD_CMD_START) &&
                        (req_i.wdata[15:0] != ISD_CMD_STOP);
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_DELAY}: begin
                    rsp_d.rdata = delay_q;
                    rsp_d.abort = wr;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_MISSED}: begin
                    rsp_d.rdata = {16'h0000, missed_q};
                    rsp_d.abort = wr;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_OVERRUN}: begin
                    rsp_d.rdata = {16'h0000, overrun_q};
                    rsp_d.abort = wr;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_SHORT}: begin
                    rsp_d.rdata = {16'h0000, short_q};
                    rsp_d.abort = wr;
                end
                {ISD_IDX_SYNC_IN, ISD_SUB_SYNC_ERR}: begin
                    rsp_d.rdata = {31'h0000_0000, sync_err_q};
                    rsp_d.abort = wr;
                end
                {ISD_IDX_PROFILE, ISD_SUB_PROF_COUNT}: begin
                    rsp_d.rdata = {24'h00_0000, ISD_PROF_COUNT};
                    rsp_d.abort = wr;
                end
                {ISD_IDX_PROFILE, ISD_SUB_PROF_SPACING}: begin
                    rsp_d.rdata = {16'h0000, ISD_PROF_SPACING};
                    rsp_d.abort = wr;
                end
                {ISD_IDX_PROFILE, ISD_SUB_PROF_CHANNELS}: begin
                    rsp_d.rdata = {16'h0000, ISD_PROF_CHANNELS};
                    rsp_d.abort = wr;
                end
                default: begin
                    rsp_d.abort = 1'b1;
                end
            endcase
            // Writes never echo data back
            if (wr) begin
                rsp_d.rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rsp_valid_q <= 1'b0;
            rsp_q <= '0;
        end else begin
            rsp_valid_q <= rsp_valid_d;
            rsp_q <= rsp_d;
        end
    end

    // Response data lasts one cycle; with no access it reads zero
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_o = rsp_q;
    assign sync_mode_o = mode_q;
    assign cycle_ns_o = cycle_q;
    assign shift_ns_o = shift_q;
    assign measure_on_o = measuring;
    assign dc_mode_o = dc_mode;

endmodule

// File: isd_sync_params_checker.sv
// Checker of the parameter port and configuration outputs.
// Assumes it is bound to isd_sync_params and sees only its ports.
`timescale 1ns/100ps
module isd_sync_params_checker (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // Parameter port
    input wire logic req_valid_i,
    input wire isd_pkg::isd_req_t req_i,
    input wire logic rsp_valid_o,
    input wire isd_pkg::isd_rsp_t rsp_o,
    // Events and outputs
    input wire logic op_state_i,
    input wire isd_pkg::isd_evt_t evt_i,
    input wire isd_pkg::isd_meas_t meas_i,
    input wire isd_pkg::isd_mode_t sync_mode_o,
    input wire logic [31:0] cycle_ns_o,
    input wire logic [31:0] shift_ns_o,
    input wire logic measure_on_o,
    input wire logic dc_mode_o
);
    import isd_pkg::*;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_acc(logic w, logic [7:0] sb);
        req_valid_i && req_i.write == w && req_i.index == ISD_IDX_SYNC_IN &&
            req_i.subindex == sb;
    endsequence
    sequence s_ans(logic [31:0] v);
        rsp_valid_o && !rsp_o.abort && rsp_o.rdata == v;
    endsequence
    property p_count;
        s_acc(1'b0, ISD_SUB_COUNT) |=> s_ans(32'h20);
    endproperty
    a_count: assert property (p_count) else $error("entry count");
    property p_support;
        s_acc(1'b0, ISD_SUB_SUPPORT) |=> s_ans(32'hc007);
    endproperty
    a_support: assert property (p_support)
        else $error("mode map");
    property p_min;
        s_acc(1'b0, ISD_SUB_MIN_CYCLE) |=> s_ans(32'h0002_22e0);
    endproperty
    a_min: assert property (p_min) else $error("minimum cycle");
    property p_mode_ok;
        s_acc(1'b1, ISD_SUB_MODE) ##0
            req_i.wdata inside {32'h0, 32'h1, 32'h2, 32'h3, 32'h22}
            |=> s_ans(32'h0) ##0 sync_mode_o == $past(req_i.wdata[15:0]);
    endproperty
    a_mode_ok: assert property (p_mode_ok)
        else $error("mode write");
    property p_mode_bad;
        s_acc(1'b1, ISD_SUB_MODE) ##0 req_i.wdata[31:16] == 16'h0 ##0
            !(req_i.wdata[15:0] inside {16'h0, 16'h1, 16'h2, 16'h3, 16'h22})
            |=> rsp_o.abort && $stable(sync_mode_o);
    endproperty
    a_mode_bad: assert property (p_mode_bad)
        else $error("bad mode");
    property p_dc;
        dc_mode_o == (sync_mode_o inside {ISD_MODE_SYNC0, ISD_MODE_SYNC1});
    endproperty
    a_dc: assert property (p_dc) else $error("dc decode");
    property p_cycle;
        s_acc(1'b1, ISD_SUB_CYCLE) |=> cycle_ns_o == $past(req_i.wdata);
    endproperty
    a_cycle: assert property (p_cycle) else $error("cycle write");
    property p_ro;
        s_acc(1'b1, ISD_SUB_COPY) |=> rsp_valid_o && rsp_o.abort;
    endproperty
    a_ro: assert property (p_ro) else $error("copy writable");
    property p_start;
        s_acc(1'b1, ISD_SUB_COMMAND) ##0 req_i.wdata == 32'h1
            |=> measure_on_o && shift_ns_o == 32'h0;
    endproperty
    a_start: assert property (p_start) else $error("start");
    property p_max;
        measure_on_o && meas_i.valid && !req_valid_i
            |=> shift_ns_o >= $past(meas_i.shift_ns);
    endproperty
    a_max: assert property (p_max) else $error("maximum lost");
endmodule

bind isd_sync_params isd_sync_params_checker chk_u (.mclk_i(mclk_i),
    .arst_n_i(arst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .op_state_i(op_state_i),
    .evt_i(evt_i), .meas_i(meas_i), .sync_mode_o(sync_mode_o),
    .cycle_ns_o(cycle_ns_o), .shift_ns_o(shift_ns_o),
    .measure_on_o(measure_on_o), .dc_mode_o(dc_mode_o));

// File: isd_master_model.sv
// Master model issuing one parameter access at a time, sometimes late.
// Assumes the block answers on rsp_valid_i after the taking edge.
`timescale 1ns/100ps
module isd_master_model (
    // Clock
    input wire logic mclk_i,
    // Answer from the block
    input wire logic rsp_valid_i,
    input wire isd_pkg::isd_rsp_t rsp_i,
    // Request to the block
    output logic req_valid_o,
    output isd_pkg::isd_req_t req_o
);
    import isd_pkg::*;
    initial begin
        req_valid_o = 1'b0;
        req_o = '0;
    end
    // Command writes of 1 and 0 are issued through this task
    task automatic access(input logic w, input logic [15:0] ix,
        input logic [7:0] sb, input logic [31:0] wd,
        output isd_rsp_t rs, output logic ok);
        repeat ($urandom_range(1)) @(posedge mclk_i);
        @(posedge mclk_i);
        #1;
        req_o = '{write: w, index: ix, subindex: sb, wdata: wd};
        req_valid_o = 1'b1;
        @(posedge mclk_i);
        #1;
        req_valid_o = 1'b0;
        // Released bus shows no stale request
        req_o = ~req_o;
        ok = rsp_valid_i;
        rs = rsp_i;
    endtask
endmodule

// File: input_sync_timing_monitor_tb.sv
// Testbench of the input synchronisation parameter object.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module input_sync_timing_monitor_tb;
    import isd_pkg::*;
    localparam logic [15:0] SI = ISD_IDX_SYNC_IN;
    logic mclk_i, arst_n_i, req_valid_i, rsp_valid_o, op_state_i, ok;
    logic measure_on_o, dc_mode_o, dc;
    logic [31:0] cycle_ns_o, shift_ns_o, v, es, ec, ed;
    logic [15:0] em, eo, eh;
    isd_req_t req_i;
    isd_rsp_t rsp_o, r;
    isd_evt_t evt_i;
    isd_meas_t meas_i;
    isd_mode_t sync_mode_o;
    int err_total, total_checks;
    logic [7:0] t_sub [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
        8'h06, 8'h08, 8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h20, 8'h00, 8'h01, 8'h02};
    logic [31:0] t_val [16] = '{32'h20, 32'h22, 32'h017d_7840, 32'h0,
        32'hc007, 32'h0002_22e0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
        32'h0, 32'h2, 32'h10, 32'h1};
    logic [31:0] md [5] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h22};

    isd_sync_params dut_u (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .req_valid_i(req_valid_i), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
        .rsp_o(rsp_o), .op_state_i(op_state_i), .evt_i(evt_i),
        .meas_i(meas_i), .sync_mode_o(sync_mode_o), .cycle_ns_o(cycle_ns_o),
        .shift_ns_o(shift_ns_o), .measure_on_o(measure_on_o),
        .dc_mode_o(dc_mode_o));
    isd_master_model m_u (.mclk_i(mclk_i), .rsp_valid_i(rsp_valid_o),
        .rsp_i(rsp_o), .req_valid_o(req_valid_i), .req_o(req_i));

    initial begin
        mclk_i = 1'b0;
        forever #10 mclk_i = ~mclk_i;
    end
    function automatic logic [15:0] sat(input logic [15:0] c, input logic h);
        return (h && c != 16'hffff) ? c + 16'h1 : c;
    endfunction
    function automatic logic [31:0] mx(input logic [31:0] a,
        input logic [31:0] b);
        return a > b ? a : b;
    endfunction
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Refused accesses and all writes must answer with zero data
    task automatic acc(input logic w, input logic [15:0] ix,
        input logic [7:0] sb, input logic [31:0] wd, input logic [31:0] ex,
        input logic ab);
        m_u.access(w, ix, sb, wd, r, ok);
        check({~ok, r.abort, r.rdata}, {1'b0, ab, ex});
    endtask
    task automatic rst_table();
        for (int i = 0; i < 16; i++) begin
            acc(1'b0, i > 12 ? ISD_IDX_PROFILE : SI, t_sub[i], 32'h0,
                t_val[i], 1'b0);
        end
    endtask
    task automatic pulse(input isd_evt_t e);
        @(posedge mclk_i);
        #1 evt_i = e;
        @(posedge mclk_i);
        #1 evt_i = '0;
    endtask
    task automatic mp(input logic [31:0] s, input logic [31:0] c,
        input logic [31:0] d);
        @(posedge mclk_i);
        #1 meas_i = '{1'b1, s, c, d};
        @(posedge mclk_i);
        #1 meas_i = '0;
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        // About 66k cycles are needed; give up at 95k
        #1_900_000;
        err_total++;
        conclude();
    end
    initial begin
        arst_n_i = 1'b0;
        op_state_i = 1'b0;
        evt_i = '0;
        meas_i = '0;
        err_total = 0;
        total_checks = 0;
        void'($urandom(34706));
        repeat (6) @(posedge mclk_i);
        #1 arst_n_i = 1'b1;
        rst_table();
        for (int i = 0; i < 16; i++) begin
            if (!(i inside {1, 2, 3, 7})) begin
                acc(1'b1, i > 12 ? ISD_IDX_PROFILE : SI, t_sub[i], $urandom(),
                    32'h0, 1'b1);
            end
        end
        acc(1'b0, SI, 8'h07, 32'h0, 32'h0, 1'b1);
        acc(1'b0, 16'h1c34, 8'h01, 32'h0, 32'h0, 1'b1);
        rst_table();
        $display("reset values and refusals done");
        foreach (md[k]) begin
            acc(1'b1, SI, ISD_SUB_MODE, md[k], 32'h0, 1'b0);
            acc(1'b0, SI, ISD_SUB_MODE, 32'h0, md[k], 1'b0);
            check(34'(sync_mode_o), 34'(md[k]));
            check(34'(dc_mode_o), 34'(md[k] inside {2, 3}));
            v = $urandom_range(33, 4);
            acc(1'b1, SI, ISD_SUB_MODE, v, 32'h0, 1'b1);
            acc(1'b0, SI, ISD_SUB_MODE, 32'h0, md[k], 1'b0);
        end
        repeat (4) begin
            v = $urandom();
            acc(1'b1, SI, ISD_SUB_CYCLE, v, 32'h0, 1'b0);
            check(34'(cycle_ns_o), 34'(v));
            acc(1'b1, SI, ISD_SUB_SHIFT, ~v, 32'h0, 1'b0);
            acc(1'b0, SI, ISD_SUB_SHIFT, 32'h0, ~v, 1'b0);
        end
        $display("mode and time writes done");
        for (int n = 0; n < 2; n++) begin
            acc(1'b1, SI, ISD_SUB_COMMAND, 32'h1, 32'h0, 1'b0);
            check(34'(measure_on_o), 34'(1));
            {es, ec, ed} = '0;
            repeat (6) begin
                v = $urandom_range(20'hfffff);
                mp(v, v ^ 32'h5a5a, {v[15:0], 4'h3});
                es = mx(es, v);
                ec = mx(ec, v ^ 32'h5a5a);
                ed = mx(ed, {v[15:0], 4'h3});
            end
            acc(1'b0, SI, ISD_SUB_SHIFT, 32'h0, es, 1'b0);
            check(34'(shift_ns_o), 34'(es));
            acc(1'b0, SI, ISD_SUB_COPY, 0, ec, 1'b0);
            acc(1'b0, SI, ISD_SUB_DELAY, 0, ed, 1'b0);
            acc(1'b1, SI, ISD_SUB_COMMAND, 32'h0, 32'h0, 1'b0);
            check(34'(measure_on_o), 34'(0));
            mp(32'hffff_fff0, 32'h0, 32'h0);
            acc(1'b0, SI, ISD_SUB_SHIFT, 32'h0, es, 1'b0);
            acc(1'b1, SI, ISD_SUB_COMMAND, 32'h2, 32'h0, 1'b1);
        end
        $display("measurement done");
        {em, eo, eh} = '0;
        for (int k = 3; k >= 0; k -= 3) begin
            acc(1'b1, SI, ISD_SUB_MODE, k, 32'h0, 1'b0);
            dc = (k == 3);
            repeat (20) begin
                op_state_i = $urandom_range(1);
                v = $urandom_range(7);
                pulse({v[2:0], 2'b00});
                em = sat(em, v[2] & op_state_i & dc);
                eo = sat(eo, v[1] & op_state_i);
                eh = sat(eh, v[0] & dc);
            end
            acc(1'b0, SI, ISD_SUB_MISSED, 0, 32'(em), 1'b0);
            acc(1'b0, SI, ISD_SUB_OVERRUN, 0, 32'(eo), 1'b0);
            acc(1'b0, SI, ISD_SUB_SHORT, 0, 32'(eh), 1'b0);
        end
        pulse(5'b00011);
        acc(1'b0, SI, ISD_SUB_SYNC_ERR, 32'h0, 32'h0, 1'b0);
        acc(1'b1, SI, ISD_SUB_MODE, 32'h2, 32'h0, 1'b0);
        for (int j = 0; j < 3; j++) begin
            pulse(j == 0 ? 5'b00011 : (j == 1 ? 5'b00001 : 5'b00010));
            acc(1'b0, SI, ISD_SUB_SYNC_ERR, 0, 32'(j < 2), 1'b0);
        end
        op_state_i = 1'b1;
        @(posedge mclk_i);
        #1 evt_i = 5'b11100;
        repeat (65540) @(posedge mclk_i);
        #1 evt_i = '0;
        for (logic [7:0] s = 8'h0b; s <= 8'h0d; s++) begin
            acc(1'b0, SI, s, 32'h0, 32'hffff, 1'b0);
        end
        arst_n_i = 1'b0;
        repeat (2) @(posedge mclk_i);
        #1 arst_n_i = 1'b1;
        rst_table();
        $display("counters and second reset done");
        conclude();
    end
endmodule
